// ==== hw/reconfig_channel.sv ====
// Channel reconfiguration register space: direct, streamer and transmit PLL switch flows
`timescale 1ns/1ns
`default_nettype none
`include "reconfig_map.svh"

// Overview of operation
// - Streamer status bits report completion; host polls them until finished.
// - Lookup registers are read-only; writes never change the logical-to-physical map.
// - Channel takes its serial clock from any of four transmit PLLs.
// - Lookup 0x117 holds PLL0 code in [3:0], PLL1 code in [7:4].
// - Lookup 0x118 holds PLL2 code in [3:0], PLL3 code in [7:4].
// - Encoded byte written to 0x111 routes that physical PLL to the channel.
// - Recalibration ends only when tx, rx and pll calibration busy drop.
module reconfig_channel #(
   // Physical PLL code for each logical PLL, nibble i for logical PLL i
   parameter logic [15:0] PHYS_PLL_CODES = 16'h3210
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [12:0] reconfig_address_in,
   input wire logic reconfig_read_in,
   input wire logic reconfig_write_in,
   input wire logic [31:0] reconfig_writedata_in,
   output logic [31:0] reconfig_readdata_out,
   output logic reconfig_waitrequest_out,
   input wire logic tx_cal_busy_in,
   input wire logic rx_cal_busy_in,
   input wire logic pll_cal_busy_in,
   output logic cal_owns_bus_out,
   output logic bg_cal_en_out,
   output logic [7:0] preemph_post1_out,
   output logic [1:0] pll_route_out,
   output logic pll_route_valid_out,
   output logic stream_busy_out,
   output logic cal_idle_out
);
   localparam logic [5:0] STREAM_LOAD = 6'(`STREAM_CYC);

   reconfig_pkg::rd_state_t rd_state, next_rd_state;
   logic [31:0] next_readdata, rd_mux;
   logic [7:0] pll_sel_mux, next_pll_sel_mux, next_preemph, mem_rdata;
   logic [2:0] stream_prof, next_stream_prof;
   logic [5:0] stream_cnt, next_stream_cnt;
   logic next_cal_owns, next_bg_cal, stream_done, next_stream_done, next_stream_busy;
   logic stall, wr_ok, in_cfg, stream_reg, start_req;
   logic [3:0] pll_match;
   logic [1:0] next_route;
   logic next_route_valid, next_cal_idle;

   // Streamer registers stay reachable while it runs so the host can poll them
   assign stream_reg = (reconfig_address_in == `OFS_STREAM_CTRL) ||
                       (reconfig_address_in == `OFS_STREAM_STAT);
   assign in_cfg = (reconfig_address_in >= `OFS_CFG_BASE) &&
                   (reconfig_address_in <= `OFS_CFG_LAST) &&
                   (reconfig_address_in != `OFS_PREEMPH_POST1) &&
                   (reconfig_address_in != `OFS_PLL_SEL_MUX) &&
                   (reconfig_address_in != `OFS_PLL_LOOKUP_LO) &&
                   (reconfig_address_in != `OFS_PLL_LOOKUP_HI);
   assign stall = stream_busy_out && !stream_reg;
   assign reconfig_waitrequest_out = stall ||
      (reconfig_read_in && (rd_state != reconfig_pkg::RD_DONE));
   assign wr_ok = reconfig_write_in && !reconfig_waitrequest_out;
   assign start_req = wr_ok && (reconfig_address_in == `OFS_STREAM_CTRL) &&
                      reconfig_writedata_in[`STREAM_CTRL_START] && !stream_busy_out;

   cfg_byte_ram u_cfg (
      .clk_in(clk_in),
      .addr_in(reconfig_address_in[7:0]),
      .we_in(wr_ok && in_cfg),
      .wdata_in(reconfig_writedata_in[7:0]),
      .rdata_out(mem_rdata)
   );

   // Read data source; lookup writes are never decoded, so the map cannot change
   always_comb begin
      rd_mux = 32'h00000000;
      case (reconfig_address_in)
         `OFS_BUS_ARB: rd_mux = {31'h00000000, cal_owns_bus_out};
         `OFS_PREEMPH_POST1: rd_mux = {24'h000000, preemph_post1_out};
         `OFS_PLL_SEL_MUX: rd_mux = {24'h000000, pll_sel_mux};
         `OFS_PLL_LOOKUP_LO: rd_mux = {24'h000000, PHYS_PLL_CODES[7:0]};
         `OFS_PLL_LOOKUP_HI: rd_mux = {24'h000000, PHYS_PLL_CODES[15:8]};
         `OFS_STREAM_CTRL: rd_mux = {29'h00000000, stream_prof};
         `OFS_STREAM_STAT: rd_mux = {27'h0000000, pll_cal_busy_in, rx_cal_busy_in,
                                     tx_cal_busy_in, stream_done, stream_busy_out};
         `OFS_BG_CAL: rd_mux = {31'h00000000, bg_cal_en_out};
         default: rd_mux = in_cfg ? {24'h000000, mem_rdata} : 32'h00000000;
      endcase
   end

   // Read sequencer: one cycle for the byte store, one to present data
   always_comb begin
      next_rd_state = rd_state;
      next_readdata = reconfig_readdata_out;
      case (rd_state)
         reconfig_pkg::RD_IDLE: begin
            if (reconfig_read_in && !stall) begin
               next_rd_state = reconfig_pkg::RD_FETCH;
            end
         end
         reconfig_pkg::RD_FETCH: begin
            next_readdata = rd_mux;
            next_rd_state = reconfig_pkg::RD_DONE;
         end
         reconfig_pkg::RD_DONE: next_rd_state = reconfig_pkg::RD_IDLE;
         default: next_rd_state = reconfig_pkg::RD_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_state <= reconfig_pkg::RD_IDLE;
         reconfig_readdata_out <= 32'h00000000;
      end else begin
         rd_state <= next_rd_state;
         reconfig_readdata_out <= next_readdata;
      end
   end

   // Writable control registers; lookup offsets have no write path
   // lookups stay read-only
   always_comb begin
      next_cal_owns = cal_owns_bus_out;
      next_bg_cal = bg_cal_en_out;
      next_preemph = preemph_post1_out;
      next_pll_sel_mux = pll_sel_mux;
      if (wr_ok) begin
         case (reconfig_address_in)
            `OFS_BUS_ARB: next_cal_owns = (reconfig_writedata_in[7:0] == `BUS_ARB_RETURN);
            `OFS_PREEMPH_POST1: next_preemph = reconfig_writedata_in[7:0];
            `OFS_PLL_SEL_MUX: next_pll_sel_mux = reconfig_writedata_in[7:0];
            `OFS_BG_CAL: next_bg_cal = reconfig_writedata_in[`BG_CAL_EN];
            default: next_cal_owns = cal_owns_bus_out;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cal_owns_bus_out <= `RST_CAL_OWNS;
         bg_cal_en_out <= `RST_BG_CAL;
         preemph_post1_out <= `RST_PREEMPH;
         pll_sel_mux <= `RST_PLL_SEL_MUX;
      end else begin
         cal_owns_bus_out <= next_cal_owns;
         bg_cal_en_out <= next_bg_cal;
         preemph_post1_out <= next_preemph;
         pll_sel_mux <= next_pll_sel_mux;
      end
   end

   // compare mux against each encoded physical code
   for (genvar i = 0; i < 4; i++) begin : g_pll
      logic [3:0] n;
      assign n = PHYS_PLL_CODES[4*i +: 4];
      assign pll_match[i] = (pll_sel_mux == {~n[3], n[1:0], n[3], n});
   end

   // Route decode; an unrecognised byte leaves no PLL routed
   always_comb begin
      next_route = 2'h0;
      next_route_valid = |pll_match;
      if (pll_match[3]) next_route = 2'h3;
      if (pll_match[2]) next_route = 2'h2;
      if (pll_match[1]) next_route = 2'h1;
      // calibration idle only when all three busy lines drop
      next_cal_idle = !(tx_cal_busy_in || rx_cal_busy_in || pll_cal_busy_in);
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pll_route_out <= 2'h0;
         pll_route_valid_out <= 1'b0;
         cal_idle_out <= 1'b0;
      end else begin
         pll_route_out <= next_route;
         pll_route_valid_out <= next_route_valid;
         cal_idle_out <= next_cal_idle;
      end
   end

   // Streamer: one fixed run time for every profile; done is sticky, write one to clear, set wins
   always_comb begin
      next_stream_busy = stream_busy_out;
      next_stream_cnt = stream_cnt;
      next_stream_prof = stream_prof;
      next_stream_done = stream_done;
      if (wr_ok && (reconfig_address_in == `OFS_STREAM_STAT) &&
          reconfig_writedata_in[`STAT_DONE]) begin
         next_stream_done = 1'b0;
      end
      if (start_req) begin
         next_stream_busy = 1'b1;
         next_stream_cnt = STREAM_LOAD;
         next_stream_prof = reconfig_writedata_in[`STREAM_CTRL_PROF_HI:0];
         next_stream_done = 1'b0;
      end else if (stream_busy_out) begin
         next_stream_cnt = stream_cnt - 6'h01;
         if (stream_cnt == 6'h01) begin
            next_stream_busy = 1'b0;
            next_stream_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stream_busy_out <= 1'b0;
         stream_cnt <= 6'h00;
         stream_prof <= 3'h0;
         stream_done <= 1'b0;
      end else begin
         stream_busy_out <= next_stream_busy;
         stream_cnt <= next_stream_cnt;
         stream_prof <= next_stream_prof;
         stream_done <= next_stream_done;
      end
   end

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_read_at(logic [12:0] a);
      rd_state == reconfig_pkg::RD_FETCH && reconfig_address_in == a;
   endsequence
   sequence s_start;
      start_req;
   endsequence

   a_lookup_low_pair: assert property (
      s_read_at(`OFS_PLL_LOOKUP_LO) |=> reconfig_readdata_out[7:0] == PHYS_PLL_CODES[7:0])
      else $error("lookup low pair read wrong");
   a_lookup_high_pair: assert property (
      s_read_at(`OFS_PLL_LOOKUP_HI) |=> reconfig_readdata_out == {24'h0, PHYS_PLL_CODES[15:8]})
      else $error("lookup high pair read wrong");
   a_lookup_stays_ro: assert property (
      wr_ok && (reconfig_address_in == `OFS_PLL_LOOKUP_LO ||
      reconfig_address_in == `OFS_PLL_LOOKUP_HI) |-> !in_cfg ##1
      ($stable(pll_sel_mux) && $stable(preemph_post1_out)))
      else $error("lookup write altered a register");
   a_mux_routes_pll: assert property (
      wr_ok && reconfig_address_in == `OFS_PLL_SEL_MUX && reconfig_writedata_in[7:0] ==
      {~PHYS_PLL_CODES[7], PHYS_PLL_CODES[5:4], PHYS_PLL_CODES[7], PHYS_PLL_CODES[7:4]} &&
      PHYS_PLL_CODES[7:4] != PHYS_PLL_CODES[3:0]
      |=> ##1 pll_route_valid_out && pll_route_out == 2'h1)
      else $error("logical pll1 not routed");
   a_route_needs_match: assert property (
      pll_route_valid_out |-> $past(|pll_match))
      else $error("route valid without matching code");
   a_stream_finishes: assert property (
      s_start |=> stream_busy_out[*8] ##[30:33] (!stream_busy_out && stream_done))
      else $error("streamer did not finish on time");
   a_read_waits: assert property (
      rd_state == reconfig_pkg::RD_IDLE && reconfig_read_in && !stall
      |-> reconfig_waitrequest_out ##1 reconfig_waitrequest_out ##1 !reconfig_waitrequest_out)
      else $error("read wait request sequence wrong");
   a_cal_idle_level: assert property (
      (tx_cal_busy_in || rx_cal_busy_in || pll_cal_busy_in) |=> !cal_idle_out)
      else $error("calibration idle while busy");
   a_bus_return: assert property (
      wr_ok && reconfig_address_in == `OFS_BUS_ARB && reconfig_writedata_in[7:0] == 8'h01
      |=> cal_owns_bus_out)
      else $error("bus not returned to calibration");
endmodule : reconfig_channel
`default_nettype wire

// ==== common/reconfig_map.svh ====
// Register offsets, field positions, reset values and timing counts of the channel block
`ifndef RECONFIG_MAP_SVH
`define RECONFIG_MAP_SVH

`define ADDR_W 13
`define DATA_W 32

// Register offsets (reconfiguration address space)
`define OFS_BUS_ARB 13'h000
`define OFS_PREEMPH_POST1 13'h105
`define OFS_PLL_SEL_MUX 13'h111
`define OFS_PLL_LOOKUP_LO 13'h117
`define OFS_PLL_LOOKUP_HI 13'h118
`define OFS_STREAM_CTRL 13'h340
`define OFS_STREAM_STAT 13'h341
`define OFS_BG_CAL 13'h542
`define OFS_CFG_BASE 13'h100
`define OFS_CFG_LAST 13'h1FF

// Field positions
`define BUS_ARB_RETURN 8'h01
`define STREAM_CTRL_PROF_HI 2
`define STREAM_CTRL_START 7
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_TX_CAL 2
`define STAT_RX_CAL 3
`define STAT_PLL_CAL 4
`define BG_CAL_EN 0

// Reset values
`define RST_CAL_OWNS 1'b1
`define RST_PREEMPH 8'h00
`define RST_PLL_SEL_MUX 8'h00
`define RST_BG_CAL 1'b0

// Timing: streamer run time and its cycle count (least time, rounded up)
`define CLK_PERIOD_NS 50
`define STREAM_TIME_NS 2000
`define STREAM_CYC ((`STREAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== common/reconfig_pkg.sv ====
// Types shared by the reconfiguration channel block
`default_nettype none
package reconfig_pkg;
   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_FETCH = 3'b010,
      RD_DONE = 3'b100
   } rd_state_t;
endpackage : reconfig_pkg
`default_nettype wire

// ==== hw/cfg_byte_ram.sv ====
// Byte store for the general channel configuration space, registered read data
`timescale 1ns/1ns
`default_nettype none
module cfg_byte_ram (
   input wire logic clk_in,
   input wire logic [7:0] addr_in,
   input wire logic we_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:255];

   // No reset on the array; contents are whatever software last wrote
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
   end
endmodule : cfg_byte_ram
`default_nettype wire

// ==== test/host_master.sv ====
// Host master model that issues register accesses on the reconfiguration bus
`timescale 1ns/1ns
`default_nettype none
`include "reconfig_map.svh"
module host_master (
   input wire logic clk_in,
   input wire logic waitreq_in,
   input wire logic [31:0] rdata_in,
   output logic [12:0] addr_out,
   output logic rd_out,
   output logic wr_out,
   output logic [31:0] wdata_out
);
   // Idle bus at time zero
   initial begin
      addr_out = 13'h0000;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 32'h00000000;
   end

   task automatic acc(input logic [12:0] a, input logic w, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = {24'h000000, d};
      rd_out = ~w;
      wr_out = w;
      // Wait is combinational, so look mid-cycle, well before the taking edge
      #5;
      // A wait that never drops is caught by the bench's cycle ceiling
      while (waitreq_in !== 1'b0) begin
         @(negedge clk_in);
         #5;
      end
      q = rdata_in[7:0];
      @(negedge clk_in);
      rd_out = 1'b0;
      wr_out = 1'b0;
      // Released lines show the inverse, never a stale copy
      addr_out = ~a;
      wdata_out = ~wdata_out;
   endtask : acc

   // Merge the field into the value read
   task automatic rmw(input logic [12:0] a, input logic [7:0] m, input logic [7:0] d);
      logic [7:0] q;
      acc(a, 1'b0, 8'h00, q);
      acc(a, 1'b1, (q & ~m) | (d & m), q);
   endtask : rmw

   // Nibble kept, encoded, written to mux
   task automatic pll_switch(input logic [1:0] idx);
      logic [7:0] q;
      logic [3:0] n;
      acc(idx[1] ? `OFS_PLL_LOOKUP_HI : `OFS_PLL_LOOKUP_LO, 1'b0, 8'h00, q);
      n = idx[0] ? q[7:4] : q[3:0];
      rmw(`OFS_PLL_SEL_MUX, 8'hFF, {~n[3], n[1:0], n[3], n});
   endtask : pll_switch
endmodule : host_master
`default_nettype wire

// ==== test/transceiver_reconfig_pll_switch_bench.sv ====
// Self-checking bench for the channel reconfiguration register space
`timescale 1ns/1ns
`default_nettype none
`include "reconfig_map.svh"
module transceiver_reconfig_pll_switch_bench;
   // Distinct physical codes so each nibble position is visible
   localparam logic [15:0] CODES = 16'h9C41;
   typedef struct {logic [12:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic clk, rstn, rd, wr, wreq, tx_busy, rx_busy, pll_busy;
   logic cal_owns, bg_en, route_ok, s_busy, idle;
   logic [12:0] addr;
   logic [31:0] wdata, rdata;
   logic [7:0] preemph, q;
   logic [1:0] route;
   int err_total, comparisons, cycles, t0;
   // Write value, then expected readback
   row_t rows [7] = '{
      '{`OFS_PREEMPH_POST1, 8'h01, 8'h01},
      '{`OFS_PLL_LOOKUP_LO, 8'hFF, CODES[7:0]},
      '{`OFS_PLL_LOOKUP_HI, 8'h00, CODES[15:8]},
      '{13'h150, 8'hA5, 8'hA5},
      '{`OFS_BG_CAL, 8'h01, 8'h01},
      '{`OFS_BUS_ARB, 8'h00, 8'h00},
      '{13'h7FF, 8'h5A, 8'h00}};

   reconfig_channel #(.PHYS_PLL_CODES(CODES)) dut_u (.clk_in(clk), .rstn_in(rstn),
      .reconfig_address_in(addr), .reconfig_read_in(rd), .reconfig_write_in(wr),
      .reconfig_writedata_in(wdata), .reconfig_readdata_out(rdata),
      .reconfig_waitrequest_out(wreq), .tx_cal_busy_in(tx_busy),
      .rx_cal_busy_in(rx_busy), .pll_cal_busy_in(pll_busy),
      .cal_owns_bus_out(cal_owns), .bg_cal_en_out(bg_en), .preemph_post1_out(preemph),
      .pll_route_out(route), .pll_route_valid_out(route_ok),
      .stream_busy_out(s_busy), .cal_idle_out(idle));

   host_master host_u (.clk_in(clk), .waitreq_in(wreq), .rdata_in(rdata),
      .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));

   // Free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Cut a hung run short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end

   function automatic logic [7:0] enc(input logic [3:0] n);
      return {~n[3], n[1:0], n[3], n};
   endfunction : enc

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      rstn = 1'b0;
      {tx_busy, rx_busy, pll_busy} = 3'h0;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      check({bg_en, s_busy, route_ok, cal_owns, 4'h0}, 8'h10);
      check(preemph, `RST_PREEMPH);
      foreach (rows[i]) begin
         host_u.acc(rows[i].a, 1'b1, rows[i].d, q);
         host_u.acc(rows[i].a, 1'b0, 8'h00, q);
         check(q, rows[i].e);
      end
      check({preemph[3:0], bg_en, cal_owns, 2'h0}, 8'h18);
      // Only the differing low bits of a stored byte change
      host_u.rmw(13'h150, 8'h0F, 8'h03);
      host_u.acc(13'h150, 1'b0, 8'h00, q);
      check(q, 8'hA3);
      host_u.acc(`OFS_PREEMPH_POST1, 1'b1, 8'hE0, q);
      host_u.rmw(`OFS_PREEMPH_POST1, 8'h1F, 8'h01);
      check(preemph, 8'hE1);
      // Calibration off and bus taken before the switch
      host_u.rmw(`OFS_BG_CAL, 8'h01, 8'h00);
      host_u.acc(`OFS_BUS_ARB, 1'b1, 8'h00, q);
      check({6'h00, bg_en, cal_owns}, 8'h00);
      // Every logical PLL routed in turn
      for (int i = 0; i < 4; i++) begin
         host_u.pll_switch(2'(i));
         repeat (2) @(negedge clk);
         check({5'h01, 1'b0, route}, {4'h0, route_ok, 1'b0, 2'(i)});
         host_u.acc(`OFS_PLL_SEL_MUX, 1'b0, 8'h00, q);
         check(q, enc(CODES[4*i +: 4]));
      end
      // A raw lookup value selects nothing
      host_u.acc(`OFS_PLL_SEL_MUX, 1'b1, {4'h0, CODES[3:0]}, q);
      repeat (2) @(negedge clk);
      check({7'h00, route_ok}, 8'h00);
      // Bus handed back once the switch is over
      host_u.acc(`OFS_BUS_ARB, 1'b1, `BUS_ARB_RETURN, q);
      check({6'h00, bg_en, cal_owns}, 8'h01);
      // Launch a profile, poll to completion
      host_u.rmw(`OFS_STREAM_CTRL, 8'h87, 8'h83);
      q = 8'h00;
      @(negedge clk);
      check({7'h00, s_busy}, 8'h01);
      for (int n = 0; n < 60 && !q[1]; n++) begin
         host_u.acc(`OFS_STREAM_STAT, 1'b0, 8'h00, q);
      end
      check(q & 8'h03, 8'h02);
      host_u.acc(`OFS_STREAM_STAT, 1'b1, 8'h02, q);
      host_u.acc(`OFS_STREAM_STAT, 1'b0, 8'h00, q);
      check(q & 8'h03, 8'h00);
      // Control register reads back the launched profile only
      host_u.acc(`OFS_STREAM_CTRL, 1'b0, 8'h00, q);
      check(q, 8'h03);
      host_u.rmw(`OFS_STREAM_CTRL, 8'h87, 8'h81);
      t0 = cycles;
      host_u.acc(`OFS_PREEMPH_POST1, 1'b0, 8'h00, q);
      check({q[3:0], 3'h0, s_busy}, 8'h10);
      // The stalled read must have outlasted the streamer run
      check({7'h00, (cycles - t0) >= `STREAM_CYC}, 8'h01);
      // Each busy input alone blocks idle
      for (int i = 0; i < 3; i++) begin
         {pll_busy, rx_busy, tx_busy} = 3'(1 << i);
         host_u.acc(`OFS_STREAM_STAT, 1'b0, 8'h00, q);
         check({q[4:2], 4'h0, idle}, {3'(1 << i), 5'h00});
      end
      {pll_busy, rx_busy, tx_busy} = 3'h0;
      repeat (2) @(negedge clk);
      check({7'h00, idle}, 8'h01);
      // Second reset in mid-run
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      check({preemph[3:0], 3'h0, cal_owns}, 8'h01);
      test_done();
   end
endmodule : transceiver_reconfig_pll_switch_bench
`default_nettype wire
